/* File: inc/idegl_consts.svh */
// idegl constants: decode codes, address fields, reset values
`ifndef IDEGL_CONSTS_SVH
`define IDEGL_CONSTS_SVH
`define IDEGL_CODE_W      4
`define IDEGL_CODE_FDC    4'h9
`define IDEGL_CODE_CTL_FD 4'ha
`define IDEGL_CODE_CTL_MX 4'hb
`define IDEGL_CODE_TASK   4'hc
`define IDEGL_CODE_CTL_HD 4'hd
`define IDEGL_CTL_LOW3    3'h7
`define IDEGL_OUT_IDLE    1'b1
`endif

/* File: inc/idegl_pkg.sv */
// idegl package: types for host strobes and drive-side outputs
package idegl_pkg;
    typedef enum logic [1:0] {IDEGL_TGT_NONE, IDEGL_TGT_FLOPPY, IDEGL_TGT_DRIVE} idegl_tgt_e;
    typedef struct packed {
        logic [3:0] code;
        logic [2:0] addr_low;
        logic       ior_n;
        logic       iow_n;
    } idegl_host_s;
    typedef struct packed {
        logic drive0_select_n;
        logic drive1_select_n;
        logic low_byte_enable_n;
        logic high_byte_enable_n;
    } idegl_drv_s;
endpackage

/* File: hdl/idegl_decode.sv */
// idegl decode: turns select code and strobes into a target and selects
`timescale 1ns/1ns
`default_nettype none
`include "idegl_consts.svh"
module idegl_decode (
    input  wire idegl_pkg::idegl_host_s host_i,
    input  wire logic                   ide_mode_i,
    output idegl_pkg::idegl_tgt_e       tgt_o,
    output idegl_pkg::idegl_drv_s       drv_o,
    output logic                        ctl_read_o
);
    import idegl_pkg::*;
    logic active;
    logic is_ctl;
    // target steering per decode code
    always_comb begin
        active = ~host_i.ior_n | ~host_i.iow_n;
        is_ctl = (host_i.addr_low == `IDEGL_CTL_LOW3);
        tgt_o = IDEGL_TGT_NONE;
        drv_o = '{default: `IDEGL_OUT_IDLE};
        ctl_read_o = 1'b0;
        if (active) begin
            unique case (host_i.code)
                `IDEGL_CODE_CTL_FD: begin
                    tgt_o = IDEGL_TGT_FLOPPY;
                    ctl_read_o = ~host_i.ior_n & is_ctl;
                end
                `IDEGL_CODE_CTL_MX: begin
                    // reads stay with the floppy, writes go to the drive
                    tgt_o = host_i.iow_n ? IDEGL_TGT_FLOPPY : IDEGL_TGT_DRIVE;
                    ctl_read_o = ~host_i.ior_n & is_ctl;
                    if (!host_i.iow_n) begin
                        drv_o.drive1_select_n = 1'b0;
                        // a select never goes out without at least the low-byte enable
                        drv_o.low_byte_enable_n = 1'b0;
                    end
                end
                `IDEGL_CODE_TASK: begin
                    tgt_o = IDEGL_TGT_DRIVE;
                    drv_o.drive0_select_n = 1'b0;
                    drv_o.low_byte_enable_n = 1'b0;
                    drv_o.high_byte_enable_n = host_i.addr_low[0];
                end
                `IDEGL_CODE_CTL_HD: begin
                    if (ide_mode_i) begin
                        tgt_o = IDEGL_TGT_DRIVE;
                        drv_o.low_byte_enable_n = 1'b0;
                        ctl_read_o = ~host_i.ior_n & is_ctl;
                    end
                end
                default: begin
                    tgt_o = IDEGL_TGT_NONE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: hdl/idegl_bit7.sv */
// idegl bit7: direction and mux of the shared bit-7 path
`timescale 1ns/1ns
`default_nettype none
module idegl_bit7 (
    input  wire idegl_pkg::idegl_tgt_e tgt_i,
    input  wire logic                  ior_n_i,
    input  wire logic                  iow_n_i,
    input  wire logic                  ctl_read_i,
    input  wire logic                  disk_change_flag_i,
    input  wire logic                  host_bit7_pin_i,
    input  wire logic                  drive_bit7_line_i,
    output logic                       host_bit7_next_o,
    output logic                       host_bit7_oe_n_next_o,
    output logic                       drive_bit7_next_o,
    output logic                       drive_bit7_oe_n_next_o
);
    import idegl_pkg::*;
    // write drives toward the drive, read returns drive or disk-change
    always_comb begin
        drive_bit7_next_o = host_bit7_pin_i;
        drive_bit7_oe_n_next_o = ~(~iow_n_i & (tgt_i == IDEGL_TGT_DRIVE));
        host_bit7_next_o = ctl_read_i ? disk_change_flag_i : drive_bit7_line_i;
        host_bit7_oe_n_next_o = ~(~ior_n_i & (ctl_read_i | tgt_i == IDEGL_TGT_DRIVE));
    end
endmodule
`default_nettype wire

/* File: hdl/idegl_top.sv */
// idegl top: drive glue between host i/o strobes and two ide drives
`timescale 1ns/1ns
`default_nettype none
`include "idegl_consts.svh"
module idegl_top (
    input  wire  logic                   sys_clk_i,
    input  wire  logic                   rst_b_i,
    input  wire  idegl_pkg::idegl_host_s host_i,
    input  wire  logic                   ide_mode_i,
    input  wire  logic                   disk_change_flag_i,
    input  wire  logic                   host_bit7_pin_i,
    input  wire  logic                   drive_bit7_line_i,
    output idegl_pkg::idegl_drv_s        drv_o,
    output logic                         floppy_sel_o,
    output logic                         host_bit7_pin_o,
    output logic                         host_bit7_pin_oe_n_o,
    output logic                         drive_bit7_line_o,
    output logic                         drive_bit7_line_oe_n_o
);
    import idegl_pkg::*;
    typedef struct packed {
        idegl_drv_s drv;
        logic       fsel;
        logic       hb;
        logic       hoe_n;
        logic       db;
        logic       doe_n;
    } idegl_state_s;
    idegl_state_s st;
    idegl_state_s next_st;
    idegl_tgt_e   tgt;
    idegl_drv_s   drv_c;
    logic         ctl_read;
    logic         hb_c;
    logic         hoe_c;
    logic         db_c;
    logic         doe_c;
    idegl_decode u_dec (
        .host_i     (host_i),
        .ide_mode_i (ide_mode_i),
        .tgt_o      (tgt),
        .drv_o      (drv_c),
        .ctl_read_o (ctl_read)
    );
    idegl_bit7 u_b7 (
        .tgt_i                  (tgt),
        .ior_n_i                (host_i.ior_n),
        .iow_n_i                (host_i.iow_n),
        .ctl_read_i             (ctl_read),
        .disk_change_flag_i     (disk_change_flag_i),
        .host_bit7_pin_i        (host_bit7_pin_i),
        .drive_bit7_line_i      (drive_bit7_line_i),
        .host_bit7_next_o       (hb_c),
        .host_bit7_oe_n_next_o  (hoe_c),
        .drive_bit7_next_o      (db_c),
        .drive_bit7_oe_n_next_o (doe_c)
    );
    // registered outputs, one cycle behind the strobes; simpler timing closure
    always_comb begin
        next_st.drv = drv_c;
        next_st.fsel = (tgt == IDEGL_TGT_FLOPPY);
        next_st.hb = hb_c;
        next_st.hoe_n = hoe_c;
        next_st.db = db_c;
        next_st.doe_n = doe_c;
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            st <= '{drv: '{default: `IDEGL_OUT_IDLE}, fsel: 1'b0, hb: 1'b0,
                   hoe_n: 1'b1, db: 1'b0, doe_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end
    assign drv_o = st.drv;
    assign floppy_sel_o = st.fsel;
    assign host_bit7_pin_o = st.hb;
    assign host_bit7_pin_oe_n_o = st.hoe_n;
    assign drive_bit7_line_o = st.db;
    assign drive_bit7_line_oe_n_o = st.doe_n;

    // checks, one cycle after the host strobes
    AST_CODE_A_FLOPPY: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (host_i.code == `IDEGL_CODE_CTL_FD && !host_i.ior_n) |=> floppy_sel_o && drv_o.drive0_select_n)
        else $error("code a access not sent to floppy");
    AST_CODE_B_SPLIT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (host_i.code == `IDEGL_CODE_CTL_MX && !host_i.iow_n) |=> !floppy_sel_o && !drv_o.drive1_select_n
        && !drv_o.low_byte_enable_n)
        else $error("code b write not sent to drive");
    AST_CODE_C_DRIVE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (host_i.code == `IDEGL_CODE_TASK && !host_i.ior_n) |=> !drv_o.drive0_select_n && !drv_o.low_byte_enable_n)
        else $error("code c access not sent to drive");
    AST_CODE_D_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (host_i.code == `IDEGL_CODE_CTL_HD && !ide_mode_i) |=> drv_o.low_byte_enable_n)
        else $error("code d honoured outside ide mode");
    AST_CODE_D_LOW: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (host_i.code == `IDEGL_CODE_CTL_HD && ide_mode_i && !host_i.iow_n) |=> !drv_o.low_byte_enable_n)
        else $error("code d low enable missing");
    AST_WRITE_DRIVES: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (host_i.code == `IDEGL_CODE_TASK && !host_i.iow_n) |=> !drive_bit7_line_oe_n_o
        && drive_bit7_line_o == $past(host_bit7_pin_i))
        else $error("bit7 not driven on write");
    AST_READ_PASS: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (host_i.code == `IDEGL_CODE_TASK && !host_i.ior_n && host_i.iow_n) |=> drive_bit7_line_oe_n_o
        && host_bit7_pin_o == $past(drive_bit7_line_i))
        else $error("bit7 read path wrong");
    AST_DISK_CHANGE_FLAG_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (host_i.code == `IDEGL_CODE_CTL_MX && !host_i.ior_n && host_i.iow_n
        && host_i.addr_low == `IDEGL_CTL_LOW3) |=> host_bit7_pin_o == $past(disk_change_flag_i) && !host_bit7_pin_oe_n_o)
        else $error("disk change not returned");
    AST_HIGH_EN: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !drv_o.high_byte_enable_n |-> $past(host_i.code) == `IDEGL_CODE_TASK && !$past(host_i.addr_low[0]))
        else $error("high enable without cause");
    AST_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (host_i.ior_n && host_i.iow_n) |=> drv_o == '{default: 1'b1} && drive_bit7_line_oe_n_o)
        else $error("outputs not idle");
    COV_TASK16: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !drv_o.high_byte_enable_n && !drv_o.low_byte_enable_n);
    COV_DISK_CHANGE_FLAG: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !host_bit7_pin_oe_n_o && floppy_sel_o);
    COV_SEL1: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) !drv_o.drive1_select_n);
endmodule
`default_nettype wire

/* File: verification/idegl_drive_model.sv */
// idegl drive model: far-side drive answering bit 7 on host reads
`timescale 1ns/1ns
`default_nettype none
module idegl_drive_model (
    input  wire logic sys_clk_i,
    input  wire logic ior_n_i,
    input  wire logic rd_bit_i,
    input  wire logic line_oe_n_i,
    input  wire logic line_i,
    output logic      line_o
);
    logic idle_bit = 1'b0;
    // no pull on the line: a released line flips every cycle, never a stale value
    always @(negedge sys_clk_i) begin
        idle_bit <= ~idle_bit;
    end
    // glue drives on writes, the drive answers reads, otherwise released
    always_comb begin
        if (!line_oe_n_i) begin
            line_o = line_i;
        end else if (!ior_n_i) begin
            line_o = rd_bit_i;
        end else begin
            line_o = idle_bit;
        end
    end
endmodule
`default_nettype wire

/* File: verification/ide_drive_glue_logic_test.sv */
// idegl bench: directed and random host accesses checked one cycle later
`timescale 1ns/1ns
`default_nettype none
module ide_drive_glue_logic_test;
    import idegl_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    idegl_host_s host_i    = 9'h003;
    logic        ide_mode  = 1'b0;
    logic        disk_change_flag      = 1'b0;
    logic        hb7       = 1'b0;
    logic        rd_bit    = 1'b0;
    logic        db7;
    idegl_drv_s  drv_o;
    logic        fsel, h_o, h_oe_n, d_o, d_oe_n;
    logic [13:0] snap;
    logic [31:0] seed        = 32'h4f64cb17;
    int          err_total   = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    idegl_top idegl_top_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .host_i(host_i), .ide_mode_i(ide_mode),
        .disk_change_flag_i(disk_change_flag), .host_bit7_pin_i(hb7), .drive_bit7_line_i(db7), .drv_o(drv_o),
        .floppy_sel_o(fsel), .host_bit7_pin_o(h_o), .host_bit7_pin_oe_n_o(h_oe_n),
        .drive_bit7_line_o(d_o), .drive_bit7_line_oe_n_o(d_oe_n));
    idegl_drive_model idegl_drive_model_i (.sys_clk_i(sys_clk_i), .ior_n_i(host_i.ior_n), .rd_bit_i(rd_bit),
        .line_oe_n_i(d_oe_n), .line_i(d_o), .line_o(db7));

    // inputs as the design took them; outputs answer one edge later
    always @(posedge sys_clk_i) begin
        snap <= {rst_b_i, host_i, ide_mode, disk_change_flag, hb7, db7};
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            results();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // {sel0_n, sel1_n, low_n, high_n, floppy, host_oe_n, drive_oe_n, data}
    function automatic logic [7:0] expect_out(input logic [13:0] s);
        idegl_host_s h;
        logic        rd;
        h  = s[12:4];
        rd = !h.ior_n;
        if (!s[13] || (h.ior_n && h.iow_n)) return 8'hf6;
        case (h.code)
            4'ha: return {5'h1f, h.ior_n, 1'b1, rd & s[2]};
            4'hb: return rd ? {7'h7d, s[2]} : {7'h4a, s[1]};
            4'hc: return {3'b010, h.addr_low[0], 1'b0, h.ior_n, h.iow_n, rd ? s[0] : s[1]};
            4'hd: return s[3] ? {5'b11010, h.ior_n, h.iow_n, rd ? (h.addr_low[0] ? s[2] : s[0]) : s[1]} : 8'hf6;
            default: return 8'hf6;
        endcase
    endfunction

    // the data bit only counts where a pin is expected to be driven
    task automatic check_out(input logic [7:0] exp, input logic [7:0] care);
        logic [7:0] got;
        got = {drv_o, fsel, h_oe_n, d_oe_n, exp[2] ? d_o : h_o};
        comparisons++;
        if ((got & care) !== (exp & care)) begin
            err_total++;
            $display("wrong value glue outputs expected %b seen %b", exp & care, got & care);
        end
    endtask

    // check the previous cycle, then present the next access
    task automatic step(input logic [3:0] c, input logic [1:0] st, input logic [2:0] a, input logic m);
        logic [7:0] e;
        logic [7:0] care;
        @(negedge sys_clk_i);
        e    = expect_out(snap);
        care = {(snap[12:9] == 4'hd) ? 2'b00 : 2'b11, 5'h1f, !(e[2] & e[1])};
        check_out(e, care); // every output, except both selects on code d and a data bit that no pin drives
        seed     = xs(seed);
        host_i   = {c, a, st != 2'd1, st != 2'd2};
        ide_mode = m;
        disk_change_flag     = seed[0];
        hb7      = seed[1];
        rd_bit   = seed[2];
    endtask

    // codes 9 to 0 wrap, so refused codes come up too
    task automatic rand_step();
        logic [3:0] c;
        seed = xs(seed);
        c    = 4'h9 + {1'b0, seed[2:0]};
        step(c, seed[9:8], (c == 4'hc) ? seed[5:3] : {2'b11, (c != 4'hd) | seed[3]}, seed[6] | seed[7]);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        // strobes held through reset must leave outputs idle
        repeat (8) step(4'hc, 2'd1, 3'h0, 1'b1);
        rst_b_i = 1'b1;
        for (int c = 10; c < 14; c++) begin
            for (int s = 1; s < 3; s++) begin
                step(c[3:0], s[1:0], 3'h7, 1'b1);
            end
        end
        step(4'hd, 2'd1, 3'h7, 1'b0);
        step(4'hd, 2'd1, 3'h6, 1'b1);
        step(4'hc, 2'd2, 3'h1, 1'b1);
        step(4'hc, 2'd1, 3'h0, 1'b1);
        repeat (400) rand_step();
        // reset in mid-run with the last random access still pending
        rst_b_i = 1'b0;
        repeat (2) step(4'hc, 2'd2, 3'h0, 1'b1);
        rst_b_i = 1'b1;
        repeat (50) rand_step();
        repeat (2) step(4'h0, 2'd0, 3'h0, 1'b0);
        results();
    end
endmodule
`default_nettype wire
